// ---- verilog/autoboot_pkg.sv ----
// Constants and carrier types for the serial memory start-up loader.
// Assumes one system clock domain; the memory link is sampled, not clocked.
// Function
// - Strap pin high selects boot-load mode, otherwise act as ordinary serial slave.
// - In boot-load mode chip select and serial clock become driven outputs.
// - Loading starts with chip select low, clock toggling, read command shifted out.
// - Fixed 8-bit read opcode 00000011 sent first; memory returns bytes in sequence.
// - Memory bytes on serial data input are captured one after another while clocking.
// - Each loaded entry is executed as a host command; register writes replace defaults.
// - Write command byte takes three data bytes, MSB first; other commands one byte.
// - Byte E8 starts continuous conversions; loading continues afterwards.
// - Control write 78 00 01 00 with stop bit ends the sequence.
// - Bytes 64, 44, 48 write operation mode, current gain, voltage gain.
// - Byte 74 writes interrupt mask; bit 2 unmasks the low-supply flag.
package autoboot_pkg;

    // ------------------------------------------------------------
    // Command bytes and fields
    // ------------------------------------------------------------
    localparam logic [7:0] READ_OPCODE = 8'h03;
    localparam logic [7:0] CMD_START_CONT = 8'he8;
    localparam logic [7:0] CMD_WR_OPMODE = 8'h64;
    localparam logic [7:0] CMD_WR_IGAIN = 8'h44;
    localparam logic [7:0] CMD_WR_VGAIN = 8'h48;
    localparam logic [7:0] CMD_WR_MASK = 8'h74;
    localparam logic [7:0] CMD_WR_CONTROL = 8'h78;
    localparam logic [7:0] WRITE_FLAG_MASK = 8'hc1;
    localparam logic [7:0] WRITE_FLAG_VALUE = 8'h40;
    localparam int STOP_BIT_POS = 8;
    localparam int LOW_SUPPLY_FLAG_POS = 2;

    // ------------------------------------------------------------
    // Timing: serial clock half period in system clocks
    // ------------------------------------------------------------
    localparam int CLK_SYS_MHZ = 25;
    localparam int SCLK_KHZ = 1000;
    localparam int HALF_PERIOD = (CLK_SYS_MHZ * 1000) / (2 * SCLK_KHZ);
    localparam logic [4:0] HALF_COUNT = 5'(HALF_PERIOD - 1);

    typedef struct packed {
        logic valid;
        logic [7:0] cmd;
        logic [23:0] data;
    } host_cmd_s;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
        logic oe;
    } link_out_s;

endpackage

// ---- verilog/autoboot_loader.sv ----
// Start-up loader: reads a command image from a serial memory and executes it.
// Assumes memory on chip select / clock / data pins; host commands go out as one-cycle pulses.
`timescale 1ns/100ps
module autoboot_loader (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic boot_strap,
    input wire logic sdi_pin,
    output logic cs_n_out,
    output logic cs_n_oe,
    output logic sclk_out,
    output logic sclk_oe,
    output logic sdo_out,
    output logic boot_active,
    output logic boot_done,
    output autoboot_pkg::host_cmd_s host_cmd,
    output logic conv_start,
    output logic low_supply_flag_unmask
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic strap_meta, strap_sync, sdi_meta, sdi_sync;
    logic next_strap_meta, next_strap_sync, next_sdi_meta, next_sdi_sync;

    // No reset on the pin stages: the strap must be settled while reset is held,
    // since the sequencer looks at it on the first edge after release
    always_comb begin
        next_strap_meta = boot_strap;
        next_strap_sync = strap_meta;
        next_sdi_meta = sdi_pin;
        next_sdi_sync = sdi_meta;
    end

    always_ff @(posedge clk_sys) begin
        strap_meta <= next_strap_meta;
        strap_sync <= next_strap_sync;
        sdi_meta <= next_sdi_meta;
        sdi_sync <= next_sdi_sync;
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {IDLE, SEND_OP, READ_CMD, READ_DATA, DONE, SLAVE} state_e;

    state_e state, next_state;
    logic [4:0] tick, next_tick;
    logic sclk, next_sclk;
    logic [2:0] bitc, next_bitc;
    logic [7:0] shreg, next_shreg;
    logic [1:0] bytec, next_bytec;
    logic [7:0] cmd, next_cmd;
    logic [23:0] data, next_data;
    autoboot_pkg::host_cmd_s next_host_cmd;
    logic next_conv_start, next_unmask, unmask;
    logic half_end, rise, fall;
    logic [7:0] in_byte;
    logic [23:0] entry_word;

    assign half_end = (tick == autoboot_pkg::HALF_COUNT);
    assign rise = half_end && !sclk;
    assign fall = half_end && sclk;
    assign in_byte = {shreg[6:0], sdi_sync};
    assign entry_word = {data[15:0], in_byte};

    always_comb begin
        next_state = state;
        next_tick = tick;
        next_sclk = sclk;
        next_bitc = bitc;
        next_shreg = shreg;
        next_bytec = bytec;
        next_cmd = cmd;
        next_data = data;
        next_host_cmd = '0;
        next_conv_start = 1'b0;
        next_unmask = unmask;
        if (state inside {SEND_OP, READ_CMD, READ_DATA}) begin
            next_tick = half_end ? 5'h00 : tick + 5'h01;
            if (half_end) begin
                next_sclk = !sclk;
            end
        end
        unique case (state)
            IDLE: begin
                // Strap sampled once after reset release
                if (strap_sync) begin
                    next_state = SEND_OP;
                    next_shreg = autoboot_pkg::READ_OPCODE;
                    next_bitc = 3'h0;
                    next_tick = 5'h00;
                    next_sclk = 1'b0;
                end else begin
                    next_state = SLAVE;
                end
            end
            SEND_OP: begin
                // Shift on falling edge so the memory sees stable data on rising
                if (fall) begin
                    next_shreg = {shreg[6:0], 1'b0};
                    next_bitc = bitc + 3'h1;
                    if (bitc == 3'h7) begin
                        next_state = READ_CMD;
                        next_bitc = 3'h0;
                    end
                end
            end
            READ_CMD: begin
                if (rise) begin
                    next_shreg = in_byte;
                    next_bitc = bitc + 3'h1;
                    if (bitc == 3'h7) begin
                        next_bitc = 3'h0;
                        next_cmd = in_byte;
                        if ((in_byte & autoboot_pkg::WRITE_FLAG_MASK)
                            == autoboot_pkg::WRITE_FLAG_VALUE) begin
                            next_state = READ_DATA;
                            next_bytec = 2'h0;
                        end else begin
                            next_host_cmd = '{1'b1, in_byte, 24'h000000};
                            next_conv_start = (in_byte == autoboot_pkg::CMD_START_CONT);
                        end
                    end
                end
            end
            READ_DATA: begin
                if (rise) begin
                    next_shreg = in_byte;
                    next_bitc = bitc + 3'h1;
                    if (bitc == 3'h7) begin
                        next_bitc = 3'h0;
                        next_data = {data[15:0], in_byte};
                        next_bytec = bytec + 2'h1;
                        if (bytec == 2'h2) begin
                            // Opmode, gain and mask writes all go out here
                            next_host_cmd = '{1'b1, cmd, entry_word};
                            next_state = READ_CMD;
                            if (cmd == autoboot_pkg::CMD_WR_MASK) begin
                                next_unmask = in_byte[autoboot_pkg::LOW_SUPPLY_FLAG_POS];
                            end
                            if (cmd == autoboot_pkg::CMD_WR_CONTROL
                                && entry_word[autoboot_pkg::STOP_BIT_POS]) begin
                                next_state = DONE;
                                // Clock is still low at this rise point; hold it low instead of raising it
                                next_sclk = 1'b0;
                            end
                        end
                    end
                end
            end
            DONE: begin
                next_sclk = 1'b0;
            end
            SLAVE: begin
                next_sclk = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= IDLE;
            tick <= 5'h00;
            sclk <= 1'b0;
            bitc <= 3'h0;
            shreg <= 8'h00;
            bytec <= 2'h0;
            cmd <= 8'h00;
            data <= 24'h000000;
            host_cmd <= '0;
            conv_start <= 1'b0;
            unmask <= 1'b0;
        end else begin
            state <= next_state;
            tick <= next_tick;
            sclk <= next_sclk;
            bitc <= next_bitc;
            shreg <= next_shreg;
            bytec <= next_bytec;
            cmd <= next_cmd;
            data <= next_data;
            host_cmd <= next_host_cmd;
            conv_start <= next_conv_start;
            unmask <= next_unmask;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic driving;
    assign driving = state inside {SEND_OP, READ_CMD, READ_DATA};
    assign cs_n_out = !driving;
    assign cs_n_oe = driving;
    assign sclk_oe = driving;
    assign sclk_out = sclk;
    assign sdo_out = (state == SEND_OP) ? shreg[7] : 1'b0;
    assign boot_active = driving;
    assign boot_done = (state == DONE);
    assign low_supply_flag_unmask = unmask;

endmodule

// ---- sim/autoboot_props.sv ----
// Port-level assertions for the start-up loader, bound into its top module.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/100ps
module autoboot_props (
    input wire logic clk_sys, reset, cs_n_out, cs_n_oe, sclk_out, sclk_oe,
    input wire logic boot_active, boot_done, conv_start, low_supply_flag_unmask,
    input wire autoboot_pkg::host_cmd_s host_cmd
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_pins_driven: assert property (
        boot_active |-> cs_n_oe && !cs_n_out && sclk_oe) else $error("pins not driven");
    a_sclk_half: assert property (
        $rose(sclk_out) |-> sclk_out[*8]) else $error("serial clock high too short");
    a_entry_gap: assert property (
        host_cmd.valid |=> !host_cmd.valid[*8]) else $error("entries too close");
    a_conv_with: assert property (
        host_cmd.valid && host_cmd.cmd == 8'he8 |-> conv_start) else $error("no start pulse");
    a_conv_only: assert property (
        conv_start |-> host_cmd.valid && host_cmd.cmd == 8'he8) else $error("stray start");
    a_stop_ends: assert property (
        host_cmd.valid && host_cmd.cmd == 8'h78 && host_cmd.data == 24'h000100
        |-> ##[0:30] boot_done) else $error("stop write ignored");
    a_pins_freed: assert property (
        boot_done |-> !cs_n_oe && !sclk_oe && !sclk_out && !boot_active) else $error("held");
    a_mask_source: assert property (
        $changed(low_supply_flag_unmask) |-> host_cmd.cmd == 8'h74 || $past(host_cmd.cmd) == 8'h74)
        else $error("unmask changed without mask write");
    c_conv: cover property (conv_start);
    c_done: cover property ($rose(boot_done));
    c_unmask: cover property (low_supply_flag_unmask);
endmodule
bind autoboot_loader autoboot_props props (.*);

// ---- sim/eeprom_model.sv ----
// Behavioural serial memory answering the read opcode with its stored image.
// Assumes bits are taken on clock rise and changed on clock fall.
`timescale 1ns/100ps
module eeprom_model (
    input wire logic cs_n, sclk, mosi,
    output logic miso
);
    logic [7:0] img[$];
    logic [7:0] op = 8'h00;
    int n = 0;
    int k;
    initial miso = 1'b0;
    always @(negedge cs_n) n = 0;
    always @(posedge sclk) begin
        if (!cs_n) begin
            if (n < 8) op = {op[6:0], mosi};
            n++;
        end
    end
    always @(negedge sclk) begin
        if (!cs_n && n >= 8) begin
            k = n - 8;
            miso = img[k / 8][7 - k % 8];
        end
    end
    // Released line must not keep looking like valid data
    always @(posedge cs_n) miso = ~miso;
endmodule

// ---- sim/autoboot_loader_bench.sv ----
// Self-checking bench: strap-low slave run, then a random boot image.
// Assumes the package and loader are compiled first; 25 MHz clock.
`timescale 1ns/100ps
module autoboot_loader_bench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic boot_strap = 1'b0;
    logic sdi_pin, cs_n_out, cs_n_oe, sclk_out, sclk_oe, sdo_out, cs_w, sclk_w;
    logic boot_active, boot_done, conv_start, low_supply_flag_unmask;
    logic mask_exp = 1'b0;
    logic [7:0] wr_tab[4] = '{8'h64, 8'h44, 8'h48, 8'h74};
    autoboot_pkg::host_cmd_s host_cmd;
    int n_errors = 0;
    int n_compared = 0;
    logic [31:0] exp_q[$];
    // Pull-up on select, pull-down on clock once released
    assign cs_w = cs_n_oe ? cs_n_out : 1'b1;
    assign sclk_w = sclk_oe ? sclk_out : 1'b0;
    autoboot_loader dut (.*);
    eeprom_model mem (.cs_n(cs_w), .sclk(sclk_w), .mosi(sdo_out), .miso(sdi_pin));
    initial forever #20 clk_sys = ~clk_sys;
    function automatic logic is_wr(input logic [7:0] c);
        return (c & 8'hc1) == 8'h40;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic add(input logic [7:0] c, input logic [23:0] d);
        exp_q.push_back({c, is_wr(c) ? d : 24'h0});
        mem.img.push_back(c);
        if (is_wr(c)) begin
            mem.img.push_back(d[23:16]);
            mem.img.push_back(d[15:8]);
            mem.img.push_back(d[7:0]);
        end
        if (c == 8'h74) mask_exp = d[2];
    endtask
    task test_done;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        if (host_cmd.valid === 1'b1)
            check({host_cmd.cmd, is_wr(host_cmd.cmd) ? host_cmd.data : 24'h0}, exp_q.pop_front());
    end
    initial begin
        #2000000;
        n_errors++;
        test_done;
    end
    initial begin
        logic [7:0] c;
        void'($urandom(61699));
        repeat (10) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (300) @(posedge clk_sys);
        check({cs_n_oe, sclk_oe, boot_active, cs_w}, 32'h1);
        #1 reset = 1'b1;
        boot_strap = 1'b1;
        for (int i = 0; i < 8; i++) begin
            c = $urandom;
            while (is_wr(c)) c = $urandom;
            add(i[0] ? c : wr_tab[i / 2], 24'($urandom));
        end
        add(8'he8, 24'h0);
        add(wr_tab[$urandom % 4], 24'($urandom));
        add(8'h78, 24'h000100);
        repeat (10) @(posedge clk_sys);
        #1 reset = 1'b0;
        repeat (20) @(posedge clk_sys);
        // Strap is only looked at once; a late change must not abort
        #1 boot_strap = 1'b0;
        for (int i = 0; i < 20000 && boot_done !== 1'b1; i++) @(posedge clk_sys);
        repeat (40) @(posedge clk_sys);
        check(mem.op, 8'h03);
        check(exp_q.size(), 0);
        check({boot_done, cs_n_oe, sclk_oe, cs_w, sclk_w}, 32'h12);
        check(low_supply_flag_unmask, mask_exp);
        test_done;
    end
endmodule
